// *** shared/ctm_pkg.sv ***
/*
   Constants and types shared by the transmit abort, receive flag and mask
   control block. Assumes an 8-bit special-function-register access port and a
   protocol engine that reports frame events on the same clock.
*/
`default_nettype none
package ctm_pkg;
   // Register byte addresses
   localparam logic [15:0] ADDR_TCR = 16'hFFAA;
   localparam logic [15:0] ADDR_RXNEW = 16'hFFB2;
   localparam logic [15:0] ADDR_MASK_AND_SHOT_CONTROL = 16'hFFBB;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] MASK_AND_SHOT_CONTROL_WMASK = 8'hF7;
   // Transmit control register fields
   localparam int TCR_RQ0 = 0;
   localparam int TCR_AB0 = 2;
   localparam int TCR_CP0 = 4;
   localparam int TCR_PRIO = 7;
   // Mask and shot control fields
   localparam int MC_MASK_PAIR0_ENABLE = 0;
   localparam int MC_MASK_PAIR1_ENABLE = 1;
   localparam int MC_GLOBAL = 2;
   localparam int MC_ALREQ = 4;
   localparam int MC_SINGLE_SHOT_ENABLE = 5;
   localparam int MC_PRESC_LO = 6;
   // Sizes
   localparam int NUM_TX = 2;
   localparam int NUM_RX = 16;
   localparam int RXNEW_W = 8;
   localparam int RXIDX_W = 4;
   localparam int RXFIFO_DEPTH = 4;

   // Event pulses from the protocol engine
   typedef struct packed {
      logic arbStart;
      logic arbWon;
      logic arbLost;
      logic frameOk;
      logic frameErr;
   } ctm_proto_evt_t;

   // Per receive buffer compare setup
   typedef struct packed {
      logic [NUM_RX-1:0] maskHolder;
      logic [NUM_RX-1:0] useMask0;
      logic [NUM_RX-1:0] useMask1;
   } ctm_cmp_cfg_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_ARB = 3'b010,
      TX_FRAME = 3'b100
   } ctm_tx_state_t;
endpackage
`default_nettype wire

// *** hdl/ctm_fifo.sv ***
/*
   Small synchronous FIFO with valid/ready on both sides.
   Assumes one clock and a synchronous active-high reset; depth is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module ctm_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_r, rdPtr_r;
   logic [PW:0] count_r, count_nxt;
   logic inReady_r;
   wire logic push = inValid && inReady_r;
   wire logic pop = outValid && outReady;

   // Ready is registered so the source sees a clean stall
   assign count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
   assign inReady = inReady_r;
   assign outValid = (count_r != '0);
   assign outData = mem[rdPtr_r];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
         inReady_r <= 1'b0;
      end else begin
         if (push) wrPtr_r <= wrPtr_r + PW'(1);
         if (pop) rdPtr_r <= rdPtr_r + PW'(1);
         count_r <= count_nxt;
         inReady_r <= (count_nxt != (PW+1)'(DEPTH));
      end
   end

   // Storage has no reset; only written entries are read
   always_ff @(posedge ref_clk) begin
      if (push) mem[wrPtr_r] <= inData;
   end
endmodule
`default_nettype wire

// *** hdl/ctm_control.sv ***
/*
   Transmit request/abort control for two buffers, receive new-message flags
   for the first eight receive buffers, and mask / single-shot / prescaler
   control. Assumes an 8-bit register port and a protocol engine on ref_clk
   that reports arbitration and frame events as one-cycle pulses.
// Functional notes
// [R1] Writing one to an abort bit requests abort; reads one until cleared with request.
// [R2] A frame already on the bus always runs to its end.
// [R3] Abort seen before arbitration clears completion flag, frame not sent.
// [R4] Abort seen in arbitration, then arbitration lost: completion flag cleared.
// [R5] Abort during frame ending in error: completion cleared, no retry.
// [R6] Abort during frame ending cleanly: completion set, abort had no effect.
// [R7] Every abort outcome clears request and abort bits when buffer frees.
// [R8] Init clears request and abort bits; running frame ends, no retry.
// [R9] Writing zero to request or abort bits changes nothing.
// [R10] Request bits sampled right before frame start; set order irrelevant before.
// [R11] Request reads one while busy; cleared on completion with completion flag update.
// [R12] Transmit error keeps request set and retries unless single-shot.
// [R13] Software keeps buffer contents while requested and writes whole bytes.
// [R14] New-message bit per first eight buffers, set when store completes.
// [R15] Bits mirror data-new, clear with it, read-only, reset zero, init clears.
// [R16] New-message bits of buffers 0 and 2 meaningless while holding masks.
// [R17] Mask control written only after init state is confirmed.
// [R18] Pair enables make buffer 0 mask buffer 1, buffer 2 mask buffer 3.
// [R19] Global mask extends highest mask to 4-15; buffer 3 full compare.
// [R20] Frame type comes only from each buffer's own extension bit.
// [R21] Single-shot: no error retry; arbitration loss requeues once only if enabled.
// [R22] Upper prescaler bits pick quantum range, active only in quanta mode.
*/
`timescale 1ns/1ps
`default_nettype none
module ctm_control
   import ctm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [15:0] sfrAddr,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrWr,
   input wire logic sfrRd,
   output logic [7:0] sfrRdData,
   input wire logic canInit,
   input wire logic initConfirmState,
   input wire logic quantaLengthMode,
   input wire ctm_proto_evt_t protoEvt,
   output logic txReq,
   output logic txBufSel,
   output logic [NUM_TX-1:0] txDone,
   input wire logic rxStoreValid,
   input wire logic [RXIDX_W-1:0] rxStoreIdx,
   output logic rxStoreReady,
   input wire logic rxDnClrValid,
   input wire logic [RXIDX_W-1:0] rxDnClrIdx,
   output ctm_cmp_cfg_t cmpCfg,
   output logic [1:0] prescHigh
);
   // Decode a receive buffer number onto the eight flag positions
   function automatic logic [RXNEW_W-1:0] rxFlagDecode(input logic [RXIDX_W-1:0] idx);
      logic [RXNEW_W-1:0] vec;
      vec = '0;
      if (idx < RXIDX_W'(RXNEW_W)) vec[idx[2:0]] = 1'b1;
      return vec;
   endfunction

   // Pick the buffer to send from the request bits and priority
   function automatic logic pickBuf(input logic [NUM_TX-1:0] rq, input logic prio);
      return (rq[0] && rq[1]) ? prio : rq[1];
   endfunction

   // Register state
   logic [NUM_TX-1:0] tx_request_flag_r, tx_request_flag_nxt;
   logic [NUM_TX-1:0] tx_abort_flag_r, tx_abort_flag_nxt;
   logic [NUM_TX-1:0] tx_complete_flag_r, tx_complete_flag_nxt;
   logic [NUM_TX-1:0] requeued_r, requeued_nxt;
   logic [NUM_TX-1:0] txDone_r, txDone_nxt;
   logic txPrio_r;
   logic [RXNEW_W-1:0] rx_new_message_flags_r, rxNew_nxt;
   logic [7:0] mask_and_shot_control_r;
   logic [7:0] sfrRdData_r;
   logic txReq_r, txBufSel_r;
   ctm_cmp_cfg_t cmpCfg_r, cmpCfg_nxt;
   logic [1:0] prescHigh_r;
   ctm_tx_state_t txState_r, txState_nxt;
   logic activeBuf_r;

   // Register port decode
   wire logic tcrWr = sfrWr && (sfrAddr == ADDR_TCR);
   wire logic maskcWr = sfrWr && (sfrAddr == ADDR_MASK_AND_SHOT_CONTROL);
   wire logic [7:0] tcrRead = {txPrio_r, 1'b0, tx_complete_flag_r, tx_abort_flag_r, tx_request_flag_r};
   wire logic [7:0] rdMux =
      (sfrAddr == ADDR_TCR) ? tcrRead :
      (sfrAddr == ADDR_RXNEW) ? rx_new_message_flags_r :
      (sfrAddr == ADDR_MASK_AND_SHOT_CONTROL) ? mask_and_shot_control_r : RESET_BYTE;

   // Mask control fields
   wire logic mask_pair0_enable = mask_and_shot_control_r[MC_MASK_PAIR0_ENABLE];
   wire logic mask_pair1_enable = mask_and_shot_control_r[MC_MASK_PAIR1_ENABLE];
   wire logic glob = mask_and_shot_control_r[MC_GLOBAL];
   wire logic singleShot = mask_and_shot_control_r[MC_SINGLE_SHOT_ENABLE];
   wire logic arbRequeue = mask_and_shot_control_r[MC_ALREQ];
   wire logic [1:0] prescField = mask_and_shot_control_r[MC_PRESC_LO +: 2];

   // Transmit sequencing states
   wire logic stIdle = (txState_r == TX_IDLE);
   wire logic stArb = (txState_r == TX_ARB);
   wire logic stFrame = (txState_r == TX_FRAME);
   // A start in this cycle takes the buffer already offered to the engine
   wire logic startNow = stIdle && protoEvt.arbStart && txReq_r; // [R10]

   // Next transmit state; a started frame always runs out [R2]
   always_comb begin
      txState_nxt = txState_r;
      unique case (txState_r)
         TX_IDLE: begin
            if (startNow) txState_nxt = TX_ARB;
         end
         TX_ARB: begin
            if (protoEvt.arbLost) txState_nxt = TX_IDLE;
            else if (protoEvt.arbWon) txState_nxt = TX_FRAME;
         end
         TX_FRAME: begin
            if (protoEvt.frameOk || protoEvt.frameErr) txState_nxt = TX_IDLE;
         end
         default: txState_nxt = TX_IDLE;
      endcase
   end

   // Per buffer request, abort and completion bookkeeping
   always_comb begin
      logic active, finish, okFin, busyHere;
      active = 1'b0;
      finish = 1'b0;
      okFin = 1'b0;
      busyHere = 1'b0;
      tx_request_flag_nxt = tx_request_flag_r;
      tx_abort_flag_nxt = tx_abort_flag_r;
      tx_complete_flag_nxt = tx_complete_flag_r;
      requeued_nxt = requeued_r;
      txDone_nxt = '0;
      for (int b = 0; b < NUM_TX; b++) begin
         active = !stIdle && (activeBuf_r == 1'(b));
         busyHere = active || (startNow && (txBufSel_r == 1'(b)));
         finish = 1'b0;
         okFin = 1'b0;
         if (active && stFrame && protoEvt.frameOk) begin
            finish = 1'b1; // [R6] [R11]
            okFin = 1'b1;
         end else if (active && stFrame && protoEvt.frameErr) begin
            // Error keeps the request for a retry unless aborted or single-shot
            finish = tx_abort_flag_r[b] || singleShot; // [R5] [R12] [R21]
         end else if (active && stArb && protoEvt.arbLost) begin
            if (tx_abort_flag_r[b]) finish = 1'b1; // [R4]
            else if (singleShot && (!arbRequeue || requeued_r[b])) finish = 1'b1; // [R21]
            else if (singleShot) requeued_nxt[b] = 1'b1; // [R21]
         end else if (!busyHere && tx_abort_flag_r[b] && tx_request_flag_r[b]) begin
            finish = 1'b1; // [R3]
         end
         // Completion frees the buffer; flag updated only if still requested
         if (finish && tx_request_flag_r[b]) begin
            tx_request_flag_nxt[b] = 1'b0; // [R7] [R11]
            tx_abort_flag_nxt[b] = 1'b0; // [R1] [R7]
            tx_complete_flag_nxt[b] = okFin; // [R3] [R4] [R5] [R6]
            requeued_nxt[b] = 1'b0;
            txDone_nxt[b] = 1'b1;
         end
         // Only ones written take effect [R9]
         if (tcrWr && !canInit) begin
            if (sfrWrData[TCR_RQ0 + b]) begin
               tx_request_flag_nxt[b] = 1'b1;
               requeued_nxt[b] = 1'b0;
            end
            // An abort with nothing requested would be dropped anyway
            if (sfrWrData[TCR_AB0 + b] && (tx_request_flag_r[b] || sfrWrData[TCR_RQ0 + b])) begin
               tx_abort_flag_nxt[b] = 1'b1; // [R1]
            end
         end
         // Init frees both buffers; a running frame gets no retry [R8]
         if (canInit) begin
            tx_request_flag_nxt[b] = 1'b0;
            tx_abort_flag_nxt[b] = 1'b0;
            requeued_nxt[b] = 1'b0;
            txDone_nxt[b] = tx_request_flag_r[b];
         end
      end
   end

   // Transmit state and bits
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         txState_r <= TX_IDLE;
         activeBuf_r <= 1'b0;
         tx_request_flag_r <= '0;
         tx_abort_flag_r <= '0;
         tx_complete_flag_r <= '0;
         requeued_r <= '0;
         txDone_r <= '0;
         txPrio_r <= 1'b0;
      end else begin
         txState_r <= txState_nxt;
         if (startNow) activeBuf_r <= txBufSel_r; // [R10]
         tx_request_flag_r <= tx_request_flag_nxt;
         tx_abort_flag_r <= tx_abort_flag_nxt;
         tx_complete_flag_r <= tx_complete_flag_nxt;
         requeued_r <= requeued_nxt;
         txDone_r <= txDone_nxt;
         if (tcrWr) txPrio_r <= sfrWrData[TCR_PRIO];
      end
   end

   // Offer to the engine, recomputed every cycle, also while a frame runs; a start takes it [R10]
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         txReq_r <= 1'b0;
         txBufSel_r <= 1'b0;
      end else begin
         txReq_r <= |tx_request_flag_nxt;
         txBufSel_r <= pickBuf(tx_request_flag_nxt, tcrWr ? sfrWrData[TCR_PRIO] : txPrio_r);
      end
   end

   // Store events queue here so a clear in the same cycle can stall them
   logic fifoValid;
   logic [RXIDX_W-1:0] fifoIdx;
   wire logic drainReady = !rxDnClrValid;
   wire logic drainFire = fifoValid && drainReady;
   ctm_fifo #(
      .WIDTH(RXIDX_W),
      .DEPTH(RXFIFO_DEPTH)
   ) u_store_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .inValid(rxStoreValid),
      .inReady(rxStoreReady),
      .inData(rxStoreIdx),
      .outValid(fifoValid),
      .outReady(drainReady),
      .outData(fifoIdx)
   );

   // Mask holders never flag new data [R16]
   wire logic [RXNEW_W-1:0] holderMask = cmpCfg_r.maskHolder[RXNEW_W-1:0];
   wire logic [RXNEW_W-1:0] setVec = drainFire ? (rxFlagDecode(fifoIdx) & ~holderMask) : '0; // [R14]
   wire logic [RXNEW_W-1:0] clrVec = rxDnClrValid ? rxFlagDecode(rxDnClrIdx) : '0; // [R15]

   // Set wins over clear; init wins over both [R15]
   assign rxNew_nxt = canInit ? RESET_BYTE : ((rx_new_message_flags_r & ~clrVec) | setVec);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_new_message_flags_r <= RESET_BYTE; // [R15]
      end else begin
         rx_new_message_flags_r <= rxNew_nxt; // [R14]
      end
   end

   // Writes before init is confirmed would disturb the bus, so drop them [R17]
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mask_and_shot_control_r <= RESET_BYTE;
      end else if (maskcWr && initConfirmState) begin
         mask_and_shot_control_r <= sfrWrData & MASK_AND_SHOT_CONTROL_WMASK; // [R17]
      end
   end

   // Compare setup per receive buffer; ID width and frame type stay per buffer [R20]
   always_comb begin
      cmpCfg_nxt = '0;
      cmpCfg_nxt.maskHolder[0] = mask_pair0_enable; // [R18]
      cmpCfg_nxt.maskHolder[2] = mask_pair1_enable; // [R18]
      cmpCfg_nxt.useMask0[1] = mask_pair0_enable; // [R18]
      cmpCfg_nxt.useMask1[3] = mask_pair1_enable && !glob; // [R18] [R19]
      // Global mask: highest enabled one covers the upper buffers
      cmpCfg_nxt.useMask0[2] = glob && mask_pair0_enable && !mask_pair1_enable; // [R19]
      cmpCfg_nxt.useMask0[NUM_RX-1:4] = {(NUM_RX-4){glob && mask_pair0_enable && !mask_pair1_enable}}; // [R19]
      cmpCfg_nxt.useMask1[NUM_RX-1:4] = {(NUM_RX-4){glob && mask_pair1_enable}}; // [R19]
   end

   // Registered configuration and read data
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cmpCfg_r <= '0;
         prescHigh_r <= 2'b00;
         sfrRdData_r <= RESET_BYTE;
      end else begin
         cmpCfg_r <= cmpCfg_nxt;
         prescHigh_r <= quantaLengthMode ? prescField : 2'b00; // [R22]
         sfrRdData_r <= sfrRd ? rdMux : RESET_BYTE;
      end
   end

   assign sfrRdData = sfrRdData_r;
   assign txReq = txReq_r;
   assign txBufSel = txBufSel_r;
   assign txDone = txDone_r;
   assign cmpCfg = cmpCfg_r;
   assign prescHigh = prescHigh_r;
endmodule
`default_nettype wire

// *** tb/ctm_chk.sv ***
/* Checker for ctm_control: port-level relations of the register and
   compare-setup logic. Assumes single clock ref_clk, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module ctm_chk
   import ctm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [15:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrRdData,
   input wire logic canInit,
   input wire logic initConfirmState,
   input wire logic quantaLengthMode,
   input wire logic txReq,
   input wire logic [NUM_TX-1:0] txDone,
   input wire ctm_cmp_cfg_t cmpCfg,
   input wire logic [1:0] prescHigh
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Init held for two edges, the flag register read on the second
   sequence s_init_read;
      canInit ##1 canInit && sfrRd && sfrAddr == ADDR_RXNEW;
   endsequence
   // Mask write outside confirmed init, no write just before it
   sequence s_mask_refused;
      sfrWr && sfrAddr == ADDR_MASK_AND_SHOT_CONTROL && !initConfirmState && !$past(sfrWr);
   endsequence
   flags_init_a: assert property (s_init_read |=> sfrRdData == RESET_BYTE)
      else $error("flag register not cleared by init");
   cfg_hold_a: assert property (s_mask_refused |=> $stable(cmpCfg))
      else $error("refused mask write changed compare setup");
   rsv_bit_a: assert property (sfrRd && sfrAddr == ADDR_MASK_AND_SHOT_CONTROL |=> !sfrRdData[3])
      else $error("reserved mask bit read as one");
   presc_gate_a: assert property (!quantaLengthMode && !$past(quantaLengthMode) |-> prescHigh == 2'b00)
      else $error("prescaler bits active outside quanta mode");
   pair0_a: assert property (cmpCfg.maskHolder[0] == cmpCfg.useMask0[1] && !cmpCfg.maskHolder[1])
      else $error("pair zero setup wrong");
   pair1_a: assert property (cmpCfg.useMask1[3] |-> cmpCfg.maskHolder[2] && !cmpCfg.useMask1[4])
      else $error("pair one setup wrong");
   glob0_a: assert property (cmpCfg.useMask0[4] |-> cmpCfg.useMask0[15:4] == 12'hFFF && !cmpCfg.useMask0[3])
      else $error("global mask zero setup wrong");
   glob1_a: assert property (cmpCfg.useMask1[4] |-> cmpCfg.useMask1[15:4] == 12'hFFF && !cmpCfg.useMask0[4])
      else $error("global mask one setup wrong");
   done_pulse_a: assert property (txDone[0] |=> !txDone[0])
      else $error("completion pulse longer than one cycle");
   init_req_a: assert property (canInit |-> ##2 !txReq)
      else $error("request survived init");
endmodule
bind ctm_control ctm_chk chk_i (.*);
`default_nettype wire

// *** tb/ctm_engine_model.sv ***
/* Behavioural protocol engine: answers a pending request with arbitration
   and frame events. Assumes the block samples one-cycle pulses on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module ctm_engine_model
   import ctm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic txReq,
   input wire logic go,
   input wire logic slow,
   input wire logic [1:0] mode,
   output ctm_proto_evt_t protoEvt
);
   logic [3:0] step_r;
   logic [3:0] winAt;
   logic [3:0] endAt;
   // Slow mode widens the windows a test needs to slip an abort in
   assign winAt = slow ? 4'h4 : 4'h1;
   assign endAt = slow ? 4'hC : 4'h3;
   // Start, arbitration, frame end; two idle cycles let the request settle
   always_ff @(posedge ref_clk) begin
      protoEvt <= '0;
      if (reset || (step_r == 4'h1 && !txReq)) begin
         step_r <= 4'h0;
      end else if (step_r == 4'h0) begin
         protoEvt.arbStart <= go && txReq;
         step_r <= {3'b000, go && txReq};
      end else if (step_r == winAt && mode == 2'd2) begin
         protoEvt.arbLost <= 1'b1;
         step_r <= 4'hE;
      end else if (step_r == endAt) begin
         protoEvt.frameOk <= (mode == 2'd0);
         protoEvt.frameErr <= (mode == 2'd1);
         step_r <= 4'hE;
      end else begin
         protoEvt.arbWon <= (step_r == winAt);
         step_r <= step_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

// *** tb/test_can_tx_abort_rx_mask_control.sv ***
/* Self-checking bench for ctm_control with the engine model on the far
   side. Assumes the package constants and a 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module test_can_tx_abort_rx_mask_control
   import ctm_pkg::*;
;
   logic ref_clk = 0, reset = 1, sfrWr = 0, sfrRd = 0, canInit = 0, initConfirmState = 0;
   logic quantaLengthMode = 0, rxStoreValid = 0, rxDnClrValid = 0, go = 0, slow = 0;
   logic txReq, txBufSel, rxStoreReady;
   logic [15:0] sfrAddr = '0;
   logic [7:0] sfrWrData = '0, sfrRdData;
   logic [3:0] rxStoreIdx = '0, rxDnClrIdx = '0;
   logic [1:0] mode = '0, prescHigh, txDone;
   ctm_proto_evt_t protoEvt;
   ctm_cmp_cfg_t cmpCfg;
   int mismatches = 0, tests_run = 0, cycles = 0;

   ctm_control dut (.ref_clk(ref_clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
      .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .canInit(canInit),
      .initConfirmState(initConfirmState), .quantaLengthMode(quantaLengthMode), .protoEvt(protoEvt),
      .txReq(txReq), .txBufSel(txBufSel), .txDone(txDone), .rxStoreValid(rxStoreValid),
      .rxStoreIdx(rxStoreIdx), .rxStoreReady(rxStoreReady), .rxDnClrValid(rxDnClrValid),
      .rxDnClrIdx(rxDnClrIdx), .cmpCfg(cmpCfg), .prescHigh(prescHigh));
   ctm_engine_model bus_i (.ref_clk(ref_clk), .reset(reset), .txReq(txReq), .go(go), .slow(slow),
      .mode(mode), .protoEvt(protoEvt));

   // Clock and hang guard; a run of a few hundred cycles is expected
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Register port: one-cycle strobes launched off the falling edge
   // Whole-byte writes only; buffer contents never touched while requested
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk); sfrAddr = a; sfrWrData = d; sfrWr = 1;
      @(negedge ref_clk); sfrWr = 0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge ref_clk); sfrAddr = a; sfrRd = 1;
      @(negedge ref_clk); sfrRd = 0;
      chk(48'(sfrRdData), 48'(e));
   endtask
   // Waits for completion of buffer k (0/1), arbitration start (2) or win (3)
   task automatic waitev(input int k);
      int n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (!((k < 2 ? txDone[k[0]] : (k == 2 ? protoEvt.arbStart : protoEvt.arbWon)) === 1'b1) && n < 200);
      if (n == 200) chk(48'h0, 48'h1);
   endtask
   task automatic push(input logic [3:0] idx);
      @(negedge ref_clk); rxStoreValid = 1; rxStoreIdx = idx;
      @(negedge ref_clk); rxStoreValid = 0;
   endtask

   task automatic t_reset_vals;
      rd(ADDR_RXNEW, 8'h00);
      rd(ADDR_MASK_AND_SHOT_CONTROL, 8'h00);
      wr(ADDR_RXNEW, 8'hFF);
      rd(ADDR_RXNEW, 8'h00);
      rd(16'hFFB0, 8'h00);
   endtask
   task automatic t_send;
      go = 1; mode = 2'd0;
      wr(ADDR_TCR, 8'h01); waitev(0);
      rd(ADDR_TCR, 8'h10);
   endtask
   // Abort landing before start, mid-frame (clean and failed), mid-arbitration
   task automatic t_aborts;
      go = 0;
      wr(ADDR_TCR, 8'h05); waitev(0);
      rd(ADDR_TCR, 8'h00);
      go = 1; slow = 1;
      wr(ADDR_TCR, 8'h02); waitev(3); wr(ADDR_TCR, 8'h08);
      rd(ADDR_TCR, 8'h0A);
      waitev(1);
      rd(ADDR_TCR, 8'h20);
      mode = 2'd1;
      wr(ADDR_TCR, 8'h01); waitev(3); wr(ADDR_TCR, 8'h04); waitev(0);
      rd(ADDR_TCR, 8'h20);
      mode = 2'd2;
      wr(ADDR_TCR, 8'h02); waitev(2); wr(ADDR_TCR, 8'h08); waitev(1);
      rd(ADDR_TCR, 8'h00);
      slow = 0;
   endtask
   task automatic t_retry;
      mode = 2'd1;
      wr(ADDR_TCR, 8'h01); waitev(3); waitev(3); wr(ADDR_TCR, 8'h00);
      rd(ADDR_TCR, 8'h01);
      wr(ADDR_TCR, 8'h04); waitev(0); go = 0;
      rd(ADDR_TCR, 8'h00);
   endtask
   // Every mask encoding, refused write, reserved bit, prescaler gate, holder flags
   task automatic t_masks;
      logic [47:0] cfgs [8] = '{48'h0, 48'h0001_0002_0000, 48'h0004_0000_0008, 48'h0005_0002_0008,
         48'h0, 48'h0001_FFF6_0000, 48'h0004_0000_FFF0, 48'h0005_0002_FFF0};
      canInit = 1;
      wr(ADDR_MASK_AND_SHOT_CONTROL, 8'h01);
      rd(ADDR_MASK_AND_SHOT_CONTROL, 8'h00);
      rd(ADDR_RXNEW, 8'h00);
      initConfirmState = 1;
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_MASK_AND_SHOT_CONTROL, 8'(k)); repeat (2) @(negedge ref_clk);
         chk(cmpCfg, cfgs[k]);
      end
      wr(ADDR_MASK_AND_SHOT_CONTROL, 8'hFD);
      rd(ADDR_MASK_AND_SHOT_CONTROL, 8'hF5);
      chk(48'(prescHigh), 48'h0);
      quantaLengthMode = 1; repeat (2) @(negedge ref_clk);
      chk(48'(prescHigh), 48'h3);
      canInit = 0; initConfirmState = 0;
      push(4'h0); push(4'h2); repeat (3) @(negedge ref_clk);
      rd(ADDR_RXNEW, 8'h04);
   endtask
   // Single shot on: one error ends it, arbitration loss requeues once
   task automatic t_single_shot;
      int n;
      int t;
      go = 1;
      for (int m = 1; m < 3; m++) begin
         mode = 2'(m); n = 0; t = 0;
         wr(ADDR_TCR, 8'h01);
         while (txDone[0] !== 1'b1 && t < 200) begin
            @(negedge ref_clk); t++;
            n += int'(protoEvt.frameErr | protoEvt.arbLost);
         end
         chk(48'(n), 48'(m));
      end
      go = 0;
      rd(ADDR_TCR, 8'h00);
   endtask
   // Fill the event queue while clears stall draining, then drain it
   task automatic t_rx_fifo;
      logic [3:0] ids [6] = '{4'h1, 4'h3, 4'h9, 4'h6, 4'h7, 4'h7};
      int n = 0;
      rxDnClrValid = 1; rxDnClrIdx = 4'hF;
      repeat (6) begin
         @(negedge ref_clk); rxStoreValid = 1; rxStoreIdx = ids[n];
         if (rxStoreReady === 1'b1) n++;
      end
      @(negedge ref_clk); rxStoreValid = 0; rxDnClrValid = 0;
      chk(48'(n), 48'd4);
      repeat (8) @(negedge ref_clk);
      rd(ADDR_RXNEW, 8'h4E);
      @(negedge ref_clk); rxDnClrValid = 1; rxDnClrIdx = 4'h3;
      @(negedge ref_clk); rxDnClrValid = 0;
      rd(ADDR_RXNEW, 8'h46);
   endtask
   task automatic t_init_clear;
      wr(ADDR_TCR, 8'h03);
      chk(48'({txReq, txBufSel}), 48'h2);
      @(negedge ref_clk); canInit = 1;
      repeat (2) @(negedge ref_clk); canInit = 0;
      rd(ADDR_TCR, 8'h00);
      rd(ADDR_RXNEW, 8'h00);
   endtask

   // Main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(negedge ref_clk);
      reset = 0;
      t_reset_vals();
      t_send();
      t_aborts();
      t_retry();
      t_masks();
      t_single_shot();
      t_rx_fifo();
      t_init_clear();
      close_out();
   end
endmodule
`default_nettype wire
